/* File: inc/phyar_pkg.sv */
// package for the address, isolate, duplex and reset control block
package phyar_pkg;
	localparam int unsigned   SYS_CLK_HZ        = 40_000_000;
	localparam int unsigned   HW_RESET_MIN_NS   = 1000;
	localparam int unsigned   HW_RESET_CYCLES   = (HW_RESET_MIN_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned   SW_RESET_NS       = 1000;
	localparam int unsigned   SW_RESET_CYCLES   = (SW_RESET_NS * (SYS_CLK_HZ / 1_000_000)) / 1000;
	localparam int unsigned   POR_CYCLES        = 16;
	localparam logic [4:0]    REG_BMC           = 5'h00;
	localparam logic [4:0]    REG_XCVR          = 5'h19;
	localparam logic [4:0]    REG_XCVR2         = 5'h1C;
	localparam logic [4:0]    BCAST_ADDR        = 5'h1F;
	localparam int unsigned   BMC_RESET_BIT     = 15;
	localparam int unsigned   BMC_ISOLATE_BIT   = 10;
	localparam int unsigned   BMC_DUPLEX_BIT    = 8;
	localparam int unsigned   XC2_BCAST_BIT     = 11;
	localparam int unsigned   XC2_SOFTRST_BIT   = 9;
	localparam int unsigned   XC2_TSRST_BIT     = 0;
	localparam logic [15:0]   BMC_RESET_VAL     = 16'h3100;
	localparam logic [15:0]   XCVR_RESET_VAL    = 16'h0000;
	localparam logic [15:0]   XCVR2_RESET_VAL   = 16'h0000;
	localparam logic [4:0]    ADDR_STRAP_DEFAULT = 5'h01;
	localparam logic [1:0]    MGMT_START        = 2'h1;
	localparam logic [1:0]    OP_READ           = 2'h2;
	localparam logic [1:0]    OP_WRITE          = 2'h1;

	typedef struct packed {
		logic [4:0] stationAddr;
		logic       fibreMode;
		logic       negStrapZero;
		logic       negStrapOne;
		logic       negEnableStrap;
	} phyar_strap_t;

	typedef struct packed {
		logic       txEn;
		logic [3:0] txd;
		logic       rxDv;
		logic       rxEr;
		logic [3:0] rxd;
		logic       col;
		logic       crs;
	} phyar_mii_t;
endpackage : phyar_pkg

/* File: sim/phyar_ctrl_chk.sv */
// assertion checker for the control block
module phyar_ctrl_chk
	import phyar_pkg::*;
#(
	parameter int unsigned HW_RESET_HOLD = HW_RESET_CYCLES
) (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic        resetPinN,
	input wire logic        mgmtDataOe,
	input wire phyar_mii_t  miiIn,
	input wire logic        linkUp,
	input wire logic        linkByNegotiation,
	input wire phyar_mii_t  miiOut,
	input wire logic        miiOe,
	input wire logic        lineTxEn,
	input wire logic        lineIdleOnly,
	input wire logic        negotiationEnable,
	input wire logic        fullDuplex,
	input wire logic        datapathReset,
	input wire logic        timeSyncReset,
	input wire logic [15:0] clockOutCfg,
	input wire logic [15:0] clockSrcCfg
);
	localparam int RST_WIN = HW_RESET_HOLD + 4;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	iso_line_a: assert property (miiOe |-> !lineTxEn && lineIdleOnly)
		else $error("isolate lets packet data out");
	iso_tx_a: assert property (miiOe && miiIn.txEn ##1 miiOe |-> !lineTxEn)
		else $error("isolate followed transmit enable");
	rx_copy_a: assert property (!miiOe && !datapathReset |-> miiOut.rxd == $past(miiIn.rxd)
		&& miiOut.rxDv == $past(miiIn.rxDv))
		else $error("receive nibble not passed");
	full_col_a: assert property (fullDuplex && $past(fullDuplex) && !miiOe |-> !miiOut.col)
		else $error("collision in full duplex");
	full_crs_a: assert property (fullDuplex && $past(fullDuplex) && !miiOe && !datapathReset
		|-> miiOut.crs == $past(miiIn.rxDv))
		else $error("full duplex carrier wrong");
	half_crs_a: assert property (!fullDuplex && $past(!fullDuplex) && !miiOe && !datapathReset
		|-> miiOut.crs == ($past(miiIn.rxDv) || $past(miiIn.txEn)))
		else $error("half duplex carrier wrong");
	pd_half_a: assert property ((linkUp && !linkByNegotiation && negotiationEnable)[*3] |-> !fullDuplex)
		else $error("parallel detect gave full duplex");
	pin_rst_a: assert property ((!resetPinN)[*8] |-> ##[0:RST_WIN] datapathReset)
		else $error("reset pin ignored");
	por_a: assert property ($fell(reset) |-> datapathReset && miiOe)
		else $error("no internal power-on reset");
	ts_keep_a: assert property (timeSyncReset |=> $stable(clockOutCfg) && $stable(clockSrcCfg))
		else $error("clock output config lost");
	cover property (miiOe ##1 !miiOe);
	cover property (fullDuplex && !miiOe);
	cover property (!mgmtDataOe);
	cover property (timeSyncReset && !datapathReset);
	cover property (datapathReset && !timeSyncReset);
endmodule : phyar_ctrl_chk
bind phyar_ctrl phyar_ctrl_chk #(.HW_RESET_HOLD(HW_RESET_HOLD)) phyar_ctrl_chk_i (.sys_clk, .reset,
	.resetPinN, .mgmtDataOe, .miiIn, .linkUp, .linkByNegotiation, .miiOut, .miiOe, .lineTxEn,
	.lineIdleOnly, .negotiationEnable, .fullDuplex, .datapathReset, .timeSyncReset, .clockOutCfg,
	.clockSrcCfg);

/* File: sim/phyar_ctrl_tb.sv */
// self-checking bench for the control block
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fails++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module phyar_ctrl_tb
	import phyar_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned HOLD = 4;
	logic         sys_clk, reset, resetPinN, mgmtClk, mgmtDataIn, mgmtDataOut, mgmtDataOe;
	logic         linkUp, linkByNegotiation, negotiatedFull, miiOe, lineTxEn, lineIdleOnly;
	logic         negotiationEnable, fullDuplex, datapathReset, timeSyncReset;
	logic [15:0]  clockOutCfg, clockSrcCfg, rd;
	logic [4:0]   addr;
	phyar_strap_t strapPins;
	phyar_mii_t   miiIn, miiOut;
	integer       seed = 32'hcfef5958;
	int           fails, samples_checked;
	phyar_ctrl #(.HW_RESET_HOLD(HOLD)) phyar_ctrl_i (.sys_clk, .reset, .resetPinN, .strapPins,
		.mgmtClk, .mgmtDataIn, .mgmtDataOut, .mgmtDataOe, .miiIn, .linkUp, .linkByNegotiation,
		.negotiatedFull, .miiOut, .miiOe, .lineTxEn, .lineIdleOnly, .negotiationEnable,
		.fullDuplex, .datapathReset, .timeSyncReset, .clockOutCfg, .clockSrcCfg);
	phyar_sta_model phyar_sta_model_i (.sys_clk, .mgmtDataOut, .mgmtDataOe, .mgmtClk, .mgmtDataIn);
	function automatic logic [15:0] xcvrExp(input logic [4:0] a);
		return {11'h000, a};
	endfunction : xcvrExp
	task automatic final_report();
		$display("checks=%0d mismatches=%0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : final_report
	task automatic wr(input logic [4:0] a, input logic [4:0] r, input logic [15:0] d);
		phyar_sta_model_i.frame(OP_WRITE, a, r, d, rd);
		repeat (4) @(posedge sys_clk);
	endtask : wr
	task automatic rdchk(input logic [4:0] a, input logic [4:0] r, input logic [15:0] e);
		phyar_sta_model_i.frame(OP_READ, a, r, 16'h0000, rd);
		`CHK(rd, e)
	endtask : rdchk
	task automatic pinReset(input logic [4:0] a, input logic fib, input logic z);
		@(posedge sys_clk);
		strapPins <= '{a, fib, z, 1'b0, 1'b1};
		resetPinN <= 1'b0;
		repeat (HOLD + 6) @(posedge sys_clk);
		resetPinN <= 1'b1;
		repeat (40) @(posedge sys_clk);
	endtask : pinReset
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		miiIn <= phyar_mii_t'($random(seed));
		if (($random(seed) & 15) == 0) begin
			{linkUp, linkByNegotiation, negotiatedFull} <= 3'($random(seed));
		end
	end
	initial begin
		repeat (100000) @(posedge sys_clk);
		fails++;
		final_report();
	end
	initial begin
		reset = 1'b1;
		resetPinN = 1'b1;
		strapPins = '{5'h00, 1'b0, 1'b0, 1'b0, 1'b1};
		miiIn = '0;
		{linkUp, linkByNegotiation, negotiatedFull} = 3'h0;
		repeat (10) @(posedge sys_clk);
		reset <= 1'b0;
		repeat (40) @(posedge sys_clk);
		`CHK(miiOe, 1'b1)
		rdchk(5'h00, REG_XCVR, xcvrExp(5'h00));
		addr = (5'($random(seed)) & 5'h1E) | 5'h02;
		pinReset(addr, 1'b0, 1'b0);
		`CHK(miiOe, 1'b0)
		rdchk(addr, REG_XCVR, xcvrExp(addr));
		rdchk(addr, REG_BMC, BMC_RESET_VAL);
		wr(addr ^ 5'h01, REG_BMC, 16'h3500);
		rdchk(addr, REG_BMC, BMC_RESET_VAL);
		wr(addr, REG_BMC, 16'h3500);
		`CHK({miiOe, lineTxEn}, 2'h2)
		rdchk(addr, REG_BMC, 16'h3500);
		wr(BCAST_ADDR, REG_BMC, BMC_RESET_VAL);
		`CHK(miiOe, 1'b1)
		wr(addr, REG_XCVR2, 16'h0800);
		wr(BCAST_ADDR, REG_BMC, BMC_RESET_VAL);
		`CHK(miiOe, 1'b0)
		wr(addr, REG_XCVR, 16'h0000);
		`CHK(miiOe, 1'b0)
		rdchk(5'h00, REG_XCVR, 16'h0000);
		wr(5'h00, REG_BMC, 16'h8000);
		repeat (120) @(posedge sys_clk);
		rdchk(addr, REG_XCVR, xcvrExp(addr));
		rdchk(addr, REG_XCVR2, XCVR2_RESET_VAL);
		wr(addr, REG_XCVR2, 16'h0A00);
		rdchk(addr, REG_XCVR2, 16'h0800);
		rdchk(addr, REG_BMC, BMC_RESET_VAL);
		wr(addr, REG_XCVR2, 16'h0001);
		`CHK({clockOutCfg, clockSrcCfg}, 32'h00000000)
		for (int z = 0; z < 2; z++) begin
			pinReset(addr, 1'b1, 1'(z));
			`CHK({negotiationEnable, fullDuplex}, 2'(z))
		end
		final_report();
	end
endmodule : phyar_ctrl_tb

/* File: sim/phyar_sta_model.sv */
// management station model on the serial management pins
module phyar_sta_model
	import phyar_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic mgmtDataOut,
	input  wire logic mgmtDataOe,
	output logic      mgmtClk,
	output logic      mgmtDataIn
);
	timeunit 1ns;
	timeprecision 100ps;
	logic staBit;
	logic staDrv;
	// pulled-up line: high when nobody drives it
	assign mgmtDataIn = !mgmtDataOe ? mgmtDataOut : (staDrv ? staBit : 1'b1);
	initial begin
		mgmtClk = 1'b0;
		staBit  = 1'b1;
		staDrv  = 1'b0;
	end
	task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] rg,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [63:0] v;
		v = {32'hFFFFFFFF, MGMT_START, op, phy, rg, 2'h2, wd};
		rd = 16'h0000;
		for (int i = 63; i >= 0; i--) begin
			@(posedge sys_clk);
			mgmtClk <= 1'b0;
			staDrv  <= (op == OP_WRITE) || (i > 17);
			staBit  <= v[i];
			repeat (4) @(posedge sys_clk);
			if (i < 16) begin
				rd[i] = mgmtDataIn;
			end
			mgmtClk <= 1'b1;
			repeat (3) @(posedge sys_clk);
		end
		@(posedge sys_clk);
		staDrv <= 1'b0;
	endtask : frame
endmodule : phyar_sta_model

/* File: src/phyar_ctrl.sv */
// address strap, isolate, duplex and reset control with serial management slave
// Summary of operation
// RQ1: latch five address straps at power-up/hardware reset
// RQ2: answer any station address 0 to 31
// RQ3: strapped address zero starts in isolate
// RQ4: writing address zero never enters isolate
// RQ5: unconnected straps give address one
// RQ6: control bit 10 enters isolate
// RQ7: isolate ignores transmit, floats MII outputs
// RQ8: isolate still serves management transactions
// RQ9: isolate line sends only idles or pulses
// RQ10: isolate still negotiates and may link
// RQ11: broadcast bit accepts writes to 0x1F
// RQ12: half duplex carrier sense on transmit/receive
// RQ13: full duplex: no collision, receive-only carrier
// RQ14: other MII signalling same both duplexes
// RQ15: parallel detect settles on half duplex
// RQ16: fibre: no negotiation, duplex from bit 8
// RQ17: reset pin low 1 us, full reinit
// RQ18: control bit 15 resets registers, keeps straps
// RQ19: host waits 3 us after software reset
// RQ20: soft reset bit resets datapath only
// RQ21: time-sync reset keeps clock output registers
// RQ22: internal power-on reset needs no pin
// RQ23: frames start 01, opcode 10 read/01 write
// RQ24: ignore frames not addressed to us
module phyar_ctrl
	import phyar_pkg::*;
#(
	parameter int unsigned HW_RESET_HOLD = HW_RESET_CYCLES
) (
	input  wire logic        sys_clk,
	input  wire logic        reset,
	input  wire logic        resetPinN,
	input  wire phyar_strap_t strapPins,
	input  wire logic        mgmtClk,
	input  wire logic        mgmtDataIn,
	output logic             mgmtDataOut,
	output logic             mgmtDataOe,
	input  wire phyar_mii_t  miiIn,
	input  wire logic        linkUp,
	input  wire logic        linkByNegotiation,
	input  wire logic        negotiatedFull,
	output phyar_mii_t       miiOut,
	output logic             miiOe,
	output logic             lineTxEn,
	output logic             lineIdleOnly,
	output logic             negotiationEnable,
	output logic             fullDuplex,
	output logic             datapathReset,
	output logic             timeSyncReset,
	output logic [15:0]      clockOutCfg,
	output logic [15:0]      clockSrcCfg
);
	typedef enum {ST_PREAMBLE, ST_START, ST_OP, ST_PHY, ST_REG, ST_TA, ST_DATA} phyar_mstate_t;

	logic [1:0]   rstPinSync_r;
	logic [1:0]   mdcSync_r;
	logic [1:0]   mdiSync_r;
	logic         mdcPrev_r;
	logic [3:0]   porCnt_r;
	logic         porDone_r;
	logic [15:0]  pinLowCnt_r;
	logic         pinReset_r;
	logic         strapReq_r;
	phyar_strap_t straps_r;
	logic [15:0]  bmc_r;
	logic [15:0]  xcvr_r;
	logic [15:0]  xcvr2_r;
	logic [5:0]   swCnt_r;
	logic         swActive_r;
	logic         isolate_r;
	phyar_mstate_t mState_r;
	logic [5:0]   bitCnt_r;
	logic [1:0]   opCode_r;
	logic [4:0]   phyAddr_r;
	logic [4:0]   regAddr_r;
	logic [15:0]  shift_r;
	logic         respond_r;
	logic         wrStrobe_r;
	logic         mdcRise;
	logic         regReset;
	logic         fibre;
	logic         duplexFull;

	function automatic logic [15:0] readReg(input logic [4:0] a, input logic [15:0] b, input logic [15:0] x,
		input logic [15:0] x2);
		unique case (a)
			REG_BMC:   readReg = b;
			REG_XCVR:  readReg = x;
			REG_XCVR2: readReg = x2;
			default:   readReg = 16'h0000;
		endcase
	endfunction : readReg

	assign mdcRise  = mdcSync_r[1] & ~mdcPrev_r;
	assign regReset = pinReset_r | ~porDone_r;
	assign fibre    = straps_r.fibreMode;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rstPinSync_r <= 2'h0;
			mdcSync_r    <= 2'h0;
			mdiSync_r    <= 2'h3;
			mdcPrev_r    <= 1'b0;
		end else begin
			rstPinSync_r <= {rstPinSync_r[0], resetPinN};
			mdcSync_r    <= {mdcSync_r[0], mgmtClk};
			mdiSync_r    <= {mdiSync_r[0], mgmtDataIn};
			mdcPrev_r    <= mdcSync_r[1];
		end
	end

	// internal power-on reset
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			porCnt_r  <= 4'h0; // RQ22
			porDone_r <= 1'b0;
		end else if (!porDone_r) begin
			porCnt_r  <= porCnt_r + 4'h1;
			porDone_r <= (porCnt_r == 4'(POR_CYCLES - 1));
		end
	end

	// reset pin qualified by its minimum low time
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pinLowCnt_r <= 16'h0000;
			pinReset_r  <= 1'b0;
		end else if (rstPinSync_r[1]) begin
			pinLowCnt_r <= 16'h0000;
			pinReset_r  <= 1'b0;
		end else begin
			if (pinLowCnt_r != 16'hFFFF)
				pinLowCnt_r <= pinLowCnt_r + 16'h0001;
			if (pinLowCnt_r >= 16'(HW_RESET_HOLD - 1))
				pinReset_r <= 1'b1; // RQ17
		end
	end

	// strap capture after power-on and pin reset
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			strapReq_r <= 1'b1;
			straps_r   <= '{stationAddr: ADDR_STRAP_DEFAULT, default: 1'b0}; // RQ5
		end else if (regReset) begin
			strapReq_r <= 1'b1;
		end else if (strapReq_r) begin
			strapReq_r <= 1'b0;
			straps_r   <= strapPins; // RQ1 RQ17
		end
	end

	// software reset timer
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			swCnt_r    <= 6'h00;
			swActive_r <= 1'b0;
		end else if (regReset) begin
			swActive_r <= 1'b0;
		end else if (wrStrobe_r && regAddr_r == REG_BMC && shift_r[BMC_RESET_BIT]) begin
			swActive_r <= 1'b1; // RQ18
			swCnt_r    <= 6'(SW_RESET_CYCLES - 1);
		end else if (swActive_r) begin
			if (swCnt_r == 6'h00)
				swActive_r <= 1'b0;
			else
				swCnt_r <= swCnt_r - 6'h01;
		end
	end

	// register file
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			bmc_r     <= BMC_RESET_VAL;
			xcvr_r    <= XCVR_RESET_VAL;
			xcvr2_r   <= XCVR2_RESET_VAL;
			isolate_r <= 1'b0;
		end else if (regReset || strapReq_r) begin
			bmc_r     <= BMC_RESET_VAL;
			xcvr_r    <= XCVR_RESET_VAL;
			xcvr2_r   <= XCVR2_RESET_VAL;
			isolate_r <= 1'b0;
			if (!regReset) begin
				xcvr_r[4:0] <= strapPins.stationAddr; // RQ1
				isolate_r   <= (strapPins.stationAddr == 5'h00); // RQ3
				if (strapPins.fibreMode)
					bmc_r[BMC_DUPLEX_BIT] <= strapPins.negStrapZero; // RQ16
			end
		end else if (swActive_r) begin
			bmc_r       <= BMC_RESET_VAL; // RQ18
			xcvr_r      <= XCVR_RESET_VAL;
			xcvr_r[4:0] <= straps_r.stationAddr;
			xcvr2_r     <= XCVR2_RESET_VAL;
			isolate_r   <= (straps_r.stationAddr == 5'h00);
			if (fibre)
				bmc_r[BMC_DUPLEX_BIT] <= straps_r.negStrapZero;
		end else if (wrStrobe_r) begin
			unique case (regAddr_r)
				REG_BMC: begin
					bmc_r     <= shift_r;
					isolate_r <= shift_r[BMC_ISOLATE_BIT]; // RQ6
				end
				REG_XCVR:  xcvr_r <= shift_r; // RQ4
				REG_XCVR2: xcvr2_r <= shift_r;
				default: ;
			endcase
		end else begin
			if (xcvr2_r[XC2_SOFTRST_BIT])
				xcvr2_r[XC2_SOFTRST_BIT] <= 1'b0;
			if (xcvr2_r[XC2_TSRST_BIT])
				xcvr2_r[XC2_TSRST_BIT] <= 1'b0;
		end
	end

	// clock output registers survive time-sync reset
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			clockOutCfg <= 16'h0000;
			clockSrcCfg <= 16'h0000;
		end else if (regReset) begin
			clockOutCfg <= 16'h0000;
			clockSrcCfg <= 16'h0000;
		end
	end

	// serial management slave
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			mState_r    <= ST_PREAMBLE;
			bitCnt_r    <= 6'h00;
			opCode_r    <= 2'h0;
			phyAddr_r   <= 5'h00;
			regAddr_r   <= 5'h00;
			shift_r     <= 16'h0000;
			respond_r   <= 1'b0;
			wrStrobe_r  <= 1'b0;
			mgmtDataOut <= 1'b1;
			mgmtDataOe  <= 1'b1;
		end else if (regReset || swActive_r) begin
			mState_r   <= ST_PREAMBLE;
			bitCnt_r   <= 6'h00;
			respond_r  <= 1'b0;
			wrStrobe_r <= 1'b0;
			mgmtDataOe <= 1'b1;
		end else begin
			wrStrobe_r <= 1'b0;
			if (mdcRise) begin // RQ8
				unique case (mState_r)
					ST_PREAMBLE: begin
						bitCnt_r <= mdiSync_r[1] ? ((bitCnt_r == 6'd32) ? bitCnt_r : bitCnt_r + 6'h01) : 6'h00;
						if (bitCnt_r == 6'd32 && !mdiSync_r[1])
							mState_r <= ST_START;
					end
					ST_START: begin
						mState_r <= mdiSync_r[1] ? ST_OP : ST_PREAMBLE; // RQ23
						bitCnt_r <= 6'h00;
					end
					ST_OP: begin
						opCode_r <= {opCode_r[0], mdiSync_r[1]};
						bitCnt_r <= bitCnt_r + 6'h01;
						if (bitCnt_r == 6'h01) begin
							bitCnt_r <= 6'h00;
							mState_r <= ({opCode_r[0], mdiSync_r[1]} == OP_READ ||
								{opCode_r[0], mdiSync_r[1]} == OP_WRITE) ? ST_PHY : ST_PREAMBLE; // RQ23
						end
					end
					ST_PHY: begin
						phyAddr_r <= {phyAddr_r[3:0], mdiSync_r[1]};
						bitCnt_r  <= bitCnt_r + 6'h01;
						if (bitCnt_r == 6'h04) begin
							bitCnt_r <= 6'h00;
							mState_r <= ST_REG;
						end
					end
					ST_REG: begin
						regAddr_r <= {regAddr_r[3:0], mdiSync_r[1]};
						bitCnt_r  <= bitCnt_r + 6'h01;
						if (bitCnt_r == 6'h04) begin
							bitCnt_r  <= 6'h00;
							mState_r  <= ST_TA;
							respond_r <= (phyAddr_r == xcvr_r[4:0]) || // RQ2 RQ24
								(opCode_r == OP_WRITE && phyAddr_r == BCAST_ADDR && xcvr2_r[XC2_BCAST_BIT]); // RQ11
						end
					end
					ST_TA: begin
						bitCnt_r <= bitCnt_r + 6'h01;
						if (bitCnt_r == 6'h00 && opCode_r == OP_READ && respond_r) begin
							mgmtDataOut <= 1'b0;
							mgmtDataOe  <= 1'b0;
							shift_r     <= readReg(regAddr_r, bmc_r, xcvr_r, xcvr2_r);
						end
						if (bitCnt_r == 6'h01) begin
							bitCnt_r <= 6'h00;
							mState_r <= ST_DATA;
							if (opCode_r == OP_READ && respond_r) begin
								mgmtDataOut <= shift_r[15];
								shift_r     <= {shift_r[14:0], 1'b0};
							end
						end
					end
					ST_DATA: begin
						bitCnt_r <= bitCnt_r + 6'h01;
						if (opCode_r == OP_READ) begin
							mgmtDataOut <= shift_r[15];
							shift_r     <= {shift_r[14:0], 1'b0};
						end else begin
							shift_r <= {shift_r[14:0], mdiSync_r[1]};
						end
						if (bitCnt_r == 6'h0F) begin
							bitCnt_r    <= 6'd32;
							mState_r    <= ST_PREAMBLE;
							mgmtDataOe  <= 1'b1;
							mgmtDataOut <= 1'b1;
							wrStrobe_r  <= (opCode_r == OP_WRITE) && respond_r;
						end
					end
				endcase
			end
		end
	end

	// duplex resolution
	always_comb begin
		if (fibre)
			duplexFull = bmc_r[BMC_DUPLEX_BIT]; // RQ16
		else if (linkUp && !linkByNegotiation)
			duplexFull = 1'b0; // RQ15
		else if (linkUp)
			duplexFull = negotiatedFull;
		else
			duplexFull = bmc_r[BMC_DUPLEX_BIT];
	end

	// MII side and line control
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			miiOut            <= '0;
			miiOe             <= 1'b1;
			lineTxEn          <= 1'b0;
			lineIdleOnly      <= 1'b1;
			negotiationEnable <= 1'b0;
			fullDuplex        <= 1'b0;
			datapathReset     <= 1'b1;
			timeSyncReset     <= 1'b1;
		end else begin
			datapathReset     <= regReset | swActive_r | xcvr2_r[XC2_SOFTRST_BIT]; // RQ20
			timeSyncReset     <= regReset | swActive_r | xcvr2_r[XC2_TSRST_BIT]; // RQ21
			negotiationEnable <= ~fibre & bmc_r[12]; // RQ10 RQ16
			fullDuplex        <= duplexFull;
			miiOe             <= isolate_r; // RQ7
			lineTxEn          <= miiIn.txEn & ~isolate_r; // RQ7 RQ9
			lineIdleOnly      <= isolate_r | ~miiIn.txEn; // RQ9
			miiOut.txEn       <= 1'b0;
			miiOut.txd        <= 4'h0;
			miiOut.rxDv       <= miiIn.rxDv; // RQ14
			miiOut.rxEr       <= miiIn.rxEr;
			miiOut.rxd        <= miiIn.rxd;
			miiOut.col        <= duplexFull ? 1'b0 : (miiIn.txEn & miiIn.rxDv); // RQ13
			miiOut.crs        <= duplexFull ? miiIn.rxDv : (miiIn.txEn | miiIn.rxDv); // RQ12 RQ13
		end
	end
endmodule : phyar_ctrl
